// *** rtl/phw_highway_port.sv ***
// Added by the designer: the plain strobed port and the placing of the registers.
`include "phw_consts.svh"
`default_nettype none

module phw_highway_port
  import phw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire phw_bus_req_s bus_req,
  input wire phw_pins_s pins_async,
  output logic [15:0] rd_data,
  output logic txd_out,
  output logic txd_oe_n,
  output logic driver_enable_out_n,
  output logic sync_status,
  output logic sync_change_pulse,
  output logic mem_reset_state,
  output logic [1:0] bus_type
);

  ////////////////////////////////////////////////////////////////////////////
  // reset value of the whole state but bus_type, which reset takes from the strap pins

  localparam phw_cfg_s CFG_RST = '{
    standby: 1'b1,
    double_rate: 1'b0,
    fs_fall: 1'b0,
    tx_fall: 1'b0,
    rx_fall: 1'b0,
    mode: PHW_MODE_X1,
    slots: `PHW_SLOTS_RST,
    offset: `PHW_OFFSET_RST,
    idle: `PHW_IDLE_RST,
    slot_sel: 7'h00
  };

  localparam phw_state_s ST_RST = '{
    cfg: CFG_RST,
    clk_prev: 1'b0,
    fp_prev: 1'b0,
    pos_cnt: 11'h000,
    len_cnt: 12'h000,
    armed: 1'b0,
    good_cnt: 2'h0,
    in_sync: 1'b0,
    rx_shift: 8'h00,
    mem_state: PHW_MEM_RESET,
    mem_busy: 1'b1,
    sweep: 7'h00,
    rd_data: 16'h0000,
    txd: 1'b0,
    txd_oe_n: 1'b1,
    drv_en_n: 1'b1,
    sync_change: 1'b0,
    bus_type: 2'h0
  };

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // slot count from base field and mode, held inside the legal span
  function automatic logic [7:0] slot_count(input logic [6:0] base, input logic [1:0] mode);
    logic [9:0] s;
    s = {3'h0, base} + 10'h001;
    unique case (mode)
      PHW_MODE_X1: s = s;
      PHW_MODE_X2: s = {s[8:0], 1'b0};
      PHW_MODE_X4: s = {s[7:0], 2'b00};
      default: s = s;
    endcase
    if (s < {2'h0, `PHW_MIN_SLOTS})
      s = {2'h0, `PHW_MIN_SLOTS};
    if (s > {2'h0, `PHW_MAX_SLOTS})
      s = {2'h0, `PHW_MAX_SLOTS};
    return s[7:0];
  endfunction

  function automatic logic edge_pick(input logic fall, input logic r, input logic f);
    return fall ? f : r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  phw_pins_s pins;

  phw_pin_sync #(
    .WIDTH($bits(phw_pins_s))
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .d_async(pins_async),
    .d_sync(pins)
  );

  // the external reset pin is trusted to last at least four bit clocks,
  // far longer than the two-flop delay here
  logic rst_all;
  assign rst_all = reset | pins.hard_reset;

  ////////////////////////////////////////////////////////////////////////////
  // slot memories: never reset, so contents survive a hard reset

  phw_state_s st;
  phw_state_s st_next;

  logic [7:0] cfg_mem [128];
  logic [7:0] tx_mem [128];
  logic [7:0] rx_mem [128];

  logic cfg_we;
  logic [6:0] cfg_wa;
  logic [7:0] cfg_wd;
  logic tx_we;
  logic rx_we;
  logic [6:0] rx_wa;
  logic [7:0] rx_wd;

  always_ff @(posedge core_clk)
  begin
    if (cfg_we)
      cfg_mem[cfg_wa] <= cfg_wd;
    if (tx_we)
      tx_mem[st.cfg.slot_sel] <= bus_req.wdata[7:0];
    if (rx_we)
      rx_mem[rx_wa] <= rx_wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic rise;
  logic fall;
  logic fs_ev;
  logic tx_ev;
  logic rx_ev;
  logic [7:0] slots;
  logic [10:0] frame_bits;
  logic [11:0] expected;
  logic [11:0] periods;
  logic [10:0] bit_num;
  logic [10:0] ext_pos;
  logic [6:0] slot;
  logic [2:0] bit_idx;
  logic [1:0] pair_code;
  logic drive;
  logic tx_bit;

  always_comb
  begin
    st_next = st;
    st_next.sync_change = 1'b0;
    st_next.rd_data = 16'h0000;
    cfg_we = 1'b0;
    cfg_wa = st.cfg.slot_sel;
    cfg_wd = bus_req.wdata[7:0];
    tx_we = 1'b0;
    rx_we = 1'b0;

    // bit clock edges found by the core clock
    rise = pins.bit_clock & ~st.clk_prev;
    fall = ~pins.bit_clock & st.clk_prev;
    st_next.clk_prev = pins.bit_clock;
    fs_ev = edge_pick(st.cfg.fs_fall, rise, fall);
    tx_ev = edge_pick(st.cfg.tx_fall, rise, fall);
    rx_ev = edge_pick(st.cfg.rx_fall, rise, fall);

    // frame geometry
    slots = slot_count(st.cfg.slots, st.cfg.mode);
    frame_bits = {slots, 3'b000};
    expected = st.cfg.double_rate ? {frame_bits, 1'b0} : {1'b0, frame_bits};

    // period counters advance on each rising bit clock
    if (rise)
    begin
      if (st.pos_cnt + 11'h001 >= expected[10:0] && !expected[11])
        st_next.pos_cnt = 11'h000;
      else
        st_next.pos_cnt = st.pos_cnt + 11'h001;
      if (st.len_cnt != 12'hfff)
        st_next.len_cnt = st.len_cnt + 12'h001;
    end

    // frame pulse: rising sample restarts the frame and closes a length check
    periods = st.cfg.fs_fall ? st.len_cnt : st.len_cnt + 12'h001;
    if (fs_ev)
    begin
      st_next.fp_prev = pins.frame_pulse;
      if (pins.frame_pulse && !st.fp_prev)
      begin
        st_next.pos_cnt = 11'h000;
        st_next.len_cnt = 12'h000;
        st_next.armed = 1'b1;
        if (st.armed)
        begin
          if (periods == expected)
          begin
            if (st.good_cnt != `PHW_GOOD_FRAMES)
              st_next.good_cnt = st.good_cnt + 2'h1;
            if (st.good_cnt + 2'h1 >= `PHW_GOOD_FRAMES)
              st_next.in_sync = 1'b1;
          end
          else
          begin
            st_next.good_cnt = 2'h0;
            st_next.in_sync = 1'b0;
          end
        end
      end
    end
    st_next.sync_change = st_next.in_sync ^ st.in_sync;

    // external position of the bit this edge opens: a pulse edge is bit 0
    bit_num = st.cfg.double_rate ? {1'b0, st_next.pos_cnt[10:1]} : st_next.pos_cnt;
    ext_pos = bit_num + {1'b0, st.cfg.offset};
    if (ext_pos >= frame_bits)
      ext_pos = ext_pos - frame_bits;
    slot = ext_pos[9:3];
    bit_idx = ext_pos[2:0];
    pair_code = cfg_mem[slot][{bit_idx[2:1], 1'b0} +: 2];
    tx_bit = pair_code[1] ? tx_mem[slot][3'h7 - bit_idx] : st.cfg.idle[3'h7 - bit_idx];
    drive = (pair_code != `PHW_PAIR_FLOAT) && (st.mem_state == PHW_MEM_READY);

    // transmit: line and driver enable always switch together
    if (tx_ev)
    begin
      st_next.txd = tx_bit;
      st_next.txd_oe_n = ~drive;
      st_next.drv_en_n = ~drive;
    end
    // standby only gates the drivers; counters and receive keep running
    if (st.cfg.standby)
    begin
      st_next.txd_oe_n = 1'b1;
      st_next.drv_en_n = 1'b1;
    end

    // receive: in double rate take the second sample of each bit
    if (rx_ev && (!st.cfg.double_rate || st_next.pos_cnt[0]))
    begin
      st_next.rx_shift = {st.rx_shift[6:0], pins.rxd};
      if (bit_idx == 3'h7)
        rx_we = 1'b1;
    end
    rx_wa = slot;
    rx_wd = {st.rx_shift[6:0], pins.rxd};

    // register writes
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        `PHW_ADDR_CTRL:
        begin
          st_next.cfg.standby = bus_req.wdata[`PHW_CTRL_STANDBY];
          st_next.cfg.double_rate = bus_req.wdata[`PHW_CTRL_DOUBLE];
          st_next.cfg.fs_fall = bus_req.wdata[`PHW_CTRL_FS_FALL];
          st_next.cfg.tx_fall = bus_req.wdata[`PHW_CTRL_TX_FALL];
          st_next.cfg.rx_fall = bus_req.wdata[`PHW_CTRL_RX_FALL];
          st_next.cfg.mode = bus_req.wdata[`PHW_CTRL_MODE_HI:`PHW_CTRL_MODE_LO];
          if (bus_req.wdata[`PHW_CTRL_MEM_CLEAR] && st.mem_state != PHW_MEM_CLEAR)
          begin
            st_next.mem_state = PHW_MEM_CLEAR;
            st_next.sweep = 7'h00;
          end
        end
        `PHW_ADDR_SLOTS: st_next.cfg.slots = bus_req.wdata[6:0];
        `PHW_ADDR_OFFSET: st_next.cfg.offset = bus_req.wdata[9:0];
        `PHW_ADDR_IDLE: st_next.cfg.idle = bus_req.wdata[7:0];
        `PHW_ADDR_SLOT_SEL: st_next.cfg.slot_sel = bus_req.wdata[6:0];
        `PHW_ADDR_SLOT_CFG: cfg_we = 1'b1;
        `PHW_ADDR_SLOT_TX: tx_we = 1'b1;
        default: ;
      endcase
    end

    // software clear of the slot table, one entry a cycle; beats bus writes
    if (st.mem_state == PHW_MEM_CLEAR)
    begin
      cfg_we = 1'b1;
      cfg_wa = st.sweep;
      cfg_wd = 8'h00;
      st_next.sweep = st.sweep + 7'h01;
      if (st.sweep == `PHW_LAST_SLOT)
        st_next.mem_state = PHW_MEM_READY;
    end
    st_next.mem_busy = (st_next.mem_state != PHW_MEM_READY);

    // register reads, answered in the next cycle only
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `PHW_ADDR_CTRL:
          st_next.rd_data = {9'h000, st.cfg.mode, st.cfg.rx_fall, st.cfg.tx_fall,
            st.cfg.fs_fall, st.cfg.double_rate, st.cfg.standby};
        `PHW_ADDR_SLOTS: st_next.rd_data = {9'h000, st.cfg.slots};
        `PHW_ADDR_OFFSET: st_next.rd_data = {6'h00, st.cfg.offset};
        `PHW_ADDR_IDLE: st_next.rd_data = {8'h00, st.cfg.idle};
        `PHW_ADDR_SLOT_SEL: st_next.rd_data = {9'h000, st.cfg.slot_sel};
        `PHW_ADDR_SLOT_CFG: st_next.rd_data = {8'h00, cfg_mem[st.cfg.slot_sel]};
        `PHW_ADDR_SLOT_TX: st_next.rd_data = {8'h00, tx_mem[st.cfg.slot_sel]};
        `PHW_ADDR_SLOT_RX: st_next.rd_data = {8'h00, rx_mem[st.cfg.slot_sel]};
        `PHW_ADDR_STATUS:
          st_next.rd_data = {12'h000, st.bus_type,
            st.mem_state != PHW_MEM_READY, st.in_sync};
        default: st_next.rd_data = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk)
  begin
    if (rst_all)
    begin
      st <= ST_RST;
      st.bus_type <= pins.strap;
    end
    else
    begin
      st <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign rd_data = st.rd_data;
  assign txd_out = st.txd;
  assign txd_oe_n = st.txd_oe_n;
  assign driver_enable_out_n = st.drv_en_n;
  assign sync_status = st.in_sync;
  assign sync_change_pulse = st.sync_change;
  assign mem_reset_state = st.mem_busy;
  assign bus_type = st.bus_type;

endmodule // phw_highway_port

`default_nettype wire

// *** rtl/phw_consts.svh ***
`ifndef PHW_CONSTS_SVH
`define PHW_CONSTS_SVH

// register word offsets
`define PHW_ADDR_CTRL 4'h0
`define PHW_ADDR_SLOTS 4'h1
`define PHW_ADDR_OFFSET 4'h2
`define PHW_ADDR_IDLE 4'h3
`define PHW_ADDR_SLOT_SEL 4'h4
`define PHW_ADDR_SLOT_CFG 4'h5
`define PHW_ADDR_SLOT_TX 4'h6
`define PHW_ADDR_SLOT_RX 4'h7
`define PHW_ADDR_STATUS 4'h8

// control register bit positions
`define PHW_CTRL_STANDBY 0
`define PHW_CTRL_DOUBLE 1
`define PHW_CTRL_FS_FALL 2
`define PHW_CTRL_TX_FALL 3
`define PHW_CTRL_RX_FALL 4
`define PHW_CTRL_MODE_LO 5
`define PHW_CTRL_MODE_HI 6
`define PHW_CTRL_MEM_CLEAR 7

// status register bit positions
`define PHW_STAT_SYNC 0
`define PHW_STAT_MEM_RESET 1
`define PHW_STAT_BUS_LO 2
`define PHW_STAT_BUS_HI 3

// reset values
`define PHW_SLOTS_RST 7'h1f
`define PHW_OFFSET_RST 10'h000
`define PHW_IDLE_RST 8'hff

// per-pair slot codes
`define PHW_PAIR_FLOAT 2'h0
`define PHW_PAIR_IDLE 2'h1

// frame limits and supervision counts
`define PHW_MIN_SLOTS 8'h04
`define PHW_MAX_SLOTS 8'h80
`define PHW_GOOD_FRAMES 2'h2
`define PHW_LAST_SLOT 7'h7f
`define PHW_RESET_MIN_CLOCKS 4

`endif

// *** rtl/phw_pkg.sv ***
`default_nettype none

package phw_pkg;

  typedef enum logic [1:0] {
    PHW_MODE_X1 = 2'b00,
    PHW_MODE_X2 = 2'b01,
    PHW_MODE_X4 = 2'b10
  } phw_mode_e;

  typedef enum logic [1:0] {
    PHW_MEM_RESET = 2'b00,
    PHW_MEM_CLEAR = 2'b01,
    PHW_MEM_READY = 2'b10
  } phw_mem_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } phw_bus_req_s;

  typedef struct packed {
    logic bit_clock;
    logic frame_pulse;
    logic rxd;
    logic hard_reset;
    logic [1:0] strap;
  } phw_pins_s;

  typedef struct packed {
    logic standby;
    logic double_rate;
    logic fs_fall;
    logic tx_fall;
    logic rx_fall;
    logic [1:0] mode;
    logic [6:0] slots;
    logic [9:0] offset;
    logic [7:0] idle;
    logic [6:0] slot_sel;
  } phw_cfg_s;

  typedef struct packed {
    phw_cfg_s cfg;
    logic clk_prev;
    logic fp_prev;
    logic [10:0] pos_cnt;
    logic [11:0] len_cnt;
    logic armed;
    logic [1:0] good_cnt;
    logic in_sync;
    logic [7:0] rx_shift;
    phw_mem_e mem_state;
    logic mem_busy;
    logic [6:0] sweep;
    logic [15:0] rd_data;
    logic txd;
    logic txd_oe_n;
    logic drv_en_n;
    logic sync_change;
    logic [1:0] bus_type;
  } phw_state_s;

endpackage

`default_nettype wire

// *** rtl/phw_pin_sync.sv ***
`default_nettype none

module phw_pin_sync
  import phw_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d_async,
  output logic [WIDTH-1:0] d_sync
);

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      d_sync <= '0;
    end
    else
    begin
      meta_reg <= d_async;
      d_sync <= meta_reg;
    end
  end

endmodule // phw_pin_sync

`default_nettype wire

// *** testbench/phw_highway_port_asserts.sv ***
`default_nettype none

module phw_highway_port_asserts
  import phw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire phw_bus_req_s bus_req,
  input wire phw_pins_s pins_async,
  input wire logic [15:0] rd_data,
  input wire logic txd_out,
  input wire logic txd_oe_n,
  input wire logic driver_enable_out_n,
  input wire logic sync_status,
  input wire logic sync_change_pulse,
  input wire logic mem_reset_state,
  input wire logic [1:0] bus_type
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  sequence s_standby_wr;
    bus_req.wr && bus_req.addr == 4'h0 && bus_req.wdata[0];
  endsequence
  sequence s_status_rd;
    $past(bus_req.rd) && $past(bus_req.addr) == 4'h8;
  endsequence
  property p_standby;
    s_standby_wr |-> ##2 txd_oe_n [*3];
  endproperty
  property p_status;
    s_status_rd |-> rd_data == {12'h0, $past(bus_type), $past(mem_reset_state),
      $past(sync_status)};
  endproperty
  property p_rd_quiet;
    !$past(bus_req.rd) |-> rd_data == 16'h0;
  endproperty
  property p_unmapped;
    $past(bus_req.rd) && $past(bus_req.addr) > 4'h8 |-> rd_data == 16'h0;
  endproperty
  property p_drv;
    driver_enable_out_n == txd_oe_n;
  endproperty
  // one cycle of slack where the clear starts
  property p_memrst;
    mem_reset_state && $past(mem_reset_state) |-> txd_oe_n;
  endproperty
  property p_change;
    $changed(sync_status) |-> sync_change_pulse;
  endproperty
  property p_cause;
    sync_change_pulse |-> $changed(sync_status) ##1 !sync_change_pulse;
  endproperty
  property p_reset;
    disable iff (1'b0) reset |=> mem_reset_state && txd_oe_n && !sync_change_pulse;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left line driven");
  a_status: assert property (p_status) else $error("status read wrong");
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_drv: assert property (p_drv) else $error("driver enable off line state");
  a_memrst: assert property (p_memrst) else $error("driven in memory reset");
  a_change: assert property (p_change) else $error("sync change without pulse");
  a_cause: assert property (p_cause) else $error("pulse without sync change");
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule // phw_highway_port_asserts

bind phw_highway_port phw_highway_port_asserts phw_highway_port_asserts_inst (
  .core_clk(core_clk), .reset(reset), .bus_req(bus_req), .pins_async(pins_async),
  .rd_data(rd_data), .txd_out(txd_out), .txd_oe_n(txd_oe_n),
  .driver_enable_out_n(driver_enable_out_n), .sync_status(sync_status),
  .sync_change_pulse(sync_change_pulse), .mem_reset_state(mem_reset_state),
  .bus_type(bus_type));

`default_nettype wire

// *** testbench/phw_highway_model.sv ***
`default_nettype none

module phw_highway_model
  import phw_pkg::*;
(
  input wire logic [31:0] frame_len,
  output logic bit_clock,
  output logic frame_pulse,
  output logic rxd,
  output int pos
);
  timeunit 1ns;
  timeprecision 1ns;
  int cur_len = 32;
  logic [7:0] rx_byte;

  // free running, every edge 2 ns after a rising core clock edge
  initial
  begin
    bit_clock = 1'b0;
    pos = 0;
    #37;
    forever #80 bit_clock = ~bit_clock;
  end

  // a new length only takes hold at a frame boundary
  always @(negedge bit_clock)
  begin
    if (pos + 1 >= cur_len)
    begin
      pos <= 0;
      cur_len <= frame_len;
    end
    else
      pos <= pos + 1;
  end

  assign frame_pulse = (pos == 0);
  assign rx_byte = 8'h5a ^ pos[10:3];
  assign rxd = rx_byte[~pos[2:0]];
endmodule // phw_highway_model

`default_nettype wire

// *** testbench/phw_highway_port_tb_top.sv ***
`default_nettype none

module phw_highway_port_tb_top
  import phw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, bclk, fp, rxd, hrst, txd_out, txd_oe_n, drv_n, sync_status;
  logic sync_pulse, mem_rst, mon_on = 1'b0, standby_exp = 1'b0;
  logic [1:0] strap, bus_type, e;
  logic [15:0] rd_data;
  phw_bus_req_s bus_req;
  phw_pins_s pins;
  int frame_len = 32, pos, seed = 3904, miscompares = 0, cmp_count = 0, cyc = 0, n, fl;
  logic [7:0] cfg_tab [4], tx_tab [4], idle_v;
  logic [3:0] ra [4] = '{4'h1, 4'h2, 4'h3, 4'hc};
  logic [15:0] rv [4] = '{16'h1f, 16'h0, 16'hff, 16'h0};
  logic [1:0] md [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  logic dr [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int sr [4] = '{4, 2, 1, 3};

  assign pins = '{bclk, fp, rxd, hrst, strap};

  phw_highway_port phw_highway_port_inst (.core_clk(core_clk), .reset(reset),
    .bus_req(bus_req), .pins_async(pins), .rd_data(rd_data), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .driver_enable_out_n(drv_n), .sync_status(sync_status),
    .sync_change_pulse(sync_pulse), .mem_reset_state(mem_rst), .bus_type(bus_type));
  phw_highway_model phw_highway_model_inst (.frame_len(frame_len), .bit_clock(bclk),
    .frame_pulse(fp), .rxd(rxd), .pos(pos));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{w, !w, a, d};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic int frame_of(logic [1:0] m, logic d, int r);
    return ((r + 1) << m) * 8 * (d ? 2 : 1);
  endfunction

  function automatic logic [1:0] exp_pin(int b);
    logic [1:0] c;
    c = 2'(cfg_tab[b / 8] >> (2 * ((b % 8) / 2)));
    if (standby_exp || c == 2'b00)
      return 2'b10;
    return {1'b0, c[1] ? tx_tab[b / 8][7 - b % 8] : idle_v[7 - b % 8]};
  endfunction
  ////////////////////////////////////////
  // bit clock edges never meet core clock edges, so no race on mon_on
  always @(negedge bclk)
    if (mon_on)
    begin
      e = exp_pin(pos);
      check(16'(txd_oe_n), 16'(e[1]));
      check(16'(drv_n), 16'(e[1]));
      if (!e[1])
        check(16'(txd_out), 16'(e[0]));
    end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    reset = 1'b1;
    bus_req = '0;
    hrst = 1'b0;
    strap = 2'($random(seed));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    acc(1'b1, 4'h0, 16'h0081);
    for (n = 0; n < 200 && mem_rst; n++) @(posedge core_clk);
    check(16'(mem_rst), 16'h0);
    foreach (ra[i])
    begin
      acc(1'b0, ra[i], 16'h0);
      check(rd_data, rv[i]);
    end
    $display("test registers done");
    foreach (md[i])
    begin
      fl = frame_of(md[i], dr[i], sr[i]);
      acc(1'b1, 4'h0, {9'h0, md[i], 3'h0, dr[i], 1'b1});
      acc(1'b1, 4'h1, 16'(sr[i]));
      frame_len = fl + 1;
      repeat (fl * 48) @(posedge core_clk);
      check(16'(sync_status), 16'h0);
      frame_len = fl;
      for (n = 0; n < fl * 80 && !sync_status; n++) @(posedge core_clk);
      check(16'(n > fl * 24 && n < fl * 80), 16'h1);
      acc(1'b0, 4'h8, 16'h0);
      check(16'(rd_data[0]), 16'h1);
    end
    $display("test sync done");
    frame_len = 32;
    idle_v = 8'($random(seed));
    acc(1'b1, 4'h0, 16'h0);
    acc(1'b1, 4'h1, 16'h3);
    acc(1'b1, 4'h3, {8'h0, idle_v});
    for (int s = 0; s < 4; s++)
    begin
      cfg_tab[s] = (s == 0) ? 8'h1b : 8'($random(seed));
      tx_tab[s] = 8'($random(seed));
      acc(1'b1, 4'h4, 16'(s));
      acc(1'b1, 4'h5, {8'h0, cfg_tab[s]});
      acc(1'b1, 4'h6, {8'h0, tx_tab[s]});
    end
    // let the model finish its long frame and the port realign to it
    repeat (1100) @(posedge core_clk);
    mon_on = 1'b1;
    repeat (1600) @(posedge core_clk);
    mon_on = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      acc(1'b1, 4'h4, 16'(s));
      acc(1'b0, 4'h7, 16'h0);
      check(rd_data, {8'h0, 8'h5a ^ 8'(s)});
    end
    $display("test transmit done");
    acc(1'b1, 4'h0, 16'h1);
    repeat (3) @(posedge core_clk);
    standby_exp = 1'b1;
    frame_len = 33;
    mon_on = 1'b1;
    repeat (1100) @(posedge core_clk);
    mon_on = 1'b0;
    check(16'(sync_status), 16'h0);
    hrst <= 1'b1;
    repeat (130) @(posedge core_clk);
    hrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(16'(mem_rst), 16'h1);
    acc(1'b0, 4'h8, 16'h0);
    check(rd_data, {12'h0, strap, 2'b10});
    acc(1'b1, 4'h4, 16'h1);
    acc(1'b0, 4'h6, 16'h0);
    check(rd_data, {8'h0, tx_tab[1]});
    $display("test reset done");
    end_of_test();
  end
endmodule // phw_highway_port_tb_top

`default_nettype wire
